/* File: core_alu.v */
`timescale 1ns/10ps
`include "core_defines.vh"

// Byte arithmetic for accumulator and memory operations
module core_alu (
    // Operands
    input wire [7:0] i_a,
    input wire [7:0] i_b,
    input wire i_cin,
    input wire [3:0] i_fn,
    // Result
    output reg [7:0] o_res,
    output reg o_cout
);

    wire [8:0] sum; // Carry out in bit 8
    wire [8:0] diff; // Borrow in bit 8

    assign sum = {1'b0, i_a} + {1'b0, i_b};
    assign diff = {1'b0, i_a} - {1'b0, i_b};

    // One function at a time; carry kept unless the function sets it
    always @* begin
        o_res = i_a;
        o_cout = i_cin;
        case (i_fn)
            `FN_ADD: begin
                o_res = sum[7:0];
                o_cout = sum[8];
            end
            `FN_AND: begin
                o_res = i_a & i_b;
                o_cout = 1'b0;
            end
            `FN_SUB: begin
                // Carry shows a borrow, so it flags a < b
                o_res = diff[7:0];
                o_cout = diff[8];
            end
            `FN_INC: o_res = i_b + 8'h01;
            `FN_DEC: o_res = i_b - 8'h01;
            `FN_COM: begin
                o_res = ~i_a;
                o_cout = i_a[7];
            end
            `FN_RLC: begin
                o_res = {i_a[6:0], i_cin};
                o_cout = i_a[7];
            end
            `FN_SLA: begin
                o_res = {i_a[6:0], 1'b0};
                o_cout = i_a[7];
            end
            `FN_CLR: begin
                o_res = 8'h00;
                o_cout = 1'b0;
            end
            default: o_res = i_a;
        endcase
    end

endmodule

/* File: core_branch.v */
`timescale 1ns/10ps
`include "core_defines.vh"

// Branch conditions and targets, relative to the opcode address
module core_branch (
    // Instruction context
    input wire [11:0] i_pc,
    input wire [7:0] i_op,
    input wire [7:0] i_disp,
    // Tested state
    input wire i_flag_z,
    input wire i_flag_c,
    input wire i_bit,
    // Decisions
    output wire [11:0] o_rel_target,
    output reg o_rel_take,
    output wire [11:0] o_bt_target,
    output wire o_bt_take
);

    // Signed 5-bit step from the next byte gives -15..+16
    assign o_rel_target = i_pc + 12'h001 +
        {{7{i_op[4]}}, i_op[4:0]}; // RULE_12

    // Signed 8-bit step from pc+2 gives -126..+129
    assign o_bt_target = i_pc + 12'h002 +
        {{4{i_disp[7]}}, i_disp}; // RULE_14

    // Low opcode bit names the bit value that takes the branch
    assign o_bt_take = (i_bit == i_op[0]); // RULE_13

    // Condition field picks one of four flag tests
    always @* begin
        case (i_op[6:5])
            2'h0: o_rel_take = ~i_flag_z; // RULE_10
            2'h1: o_rel_take = ~i_flag_c; // RULE_10
            2'h2: o_rel_take = i_flag_z; // RULE_10
            2'h3: o_rel_take = i_flag_c; // RULE_10
            default: o_rel_take = 1'b0;
        endcase
    end

endmodule

/* File: core_defines.vh */
// Functional notes
// (RULE_01) Add/and/compare/subtract: accumulator plus memory or immediate
// (RULE_02) Clear/decrement/increment reach all 256 data addresses
// (RULE_03) Complement, rotate, shift act on accumulator only
// (RULE_04) Arithmetic/logic take 4 cycles; 1-2 bytes
// (RULE_05) Accumulator arithmetic/logic ops update zero and carry
// (RULE_06) Increment/decrement update zero, keep carry
// (RULE_07) Direct clear: 3 bytes, 4 cycles, flags kept
// (RULE_08) Short-direct increment/decrement are single byte
// (RULE_09) Shift-left is 2 bytes; complement/rotate 1
// (RULE_10) Short branches test C=1, C=0, Z=1, Z=0
// (RULE_11) Short branch: 1 byte, 2 cycles, flags kept
// (RULE_12) Short displacement 5-bit signed, -15 to +16
// (RULE_13) Bit-test branch: 3 bytes, 5 cycles, carry only
// (RULE_14) Bit-test displacement 8-bit signed, -126 to +129
// (RULE_15) Bit set/clear: 3-bit index, 2 bytes, 4 cycles
// (RULE_16) Software avoids bit ops on port registers
// (RULE_17) No-op/return/stop/wait: 1 byte, 2 cycles, flags kept
// (RULE_18) Interrupt return: 1 byte, 2 cycles, restores flags
// (RULE_19) Watchdog selected turns stop into wait
// (RULE_20) Jump and call reach any 12-bit address
// (RULE_21) Bit-test copies tested bit into carry
// (RULE_22) Long target: four opcode bits plus next byte
// (RULE_23) Short-direct registers at 80h-83h; first two pointers
// (RULE_24) Failed branch continues at following instruction
// (RULE_25) Failed branch still takes its full cycle count
`ifndef CORE_DEFINES_VH
`define CORE_DEFINES_VH

// Data space landmarks
`define ACC_ADDR 8'hFF
`define SDIR_BASE 8'h80

// Opcode classes, upper bits of the first byte
`define OPC_JMP 3'h4
`define OPC_BTB 4'hA
`define OPC_BSR 4'hB
`define OPC_ALU 4'hC
`define OPC_IDC 4'hD
`define OPC_MISC 4'hE

// Accumulator/memory operation field and operand modes
`define AOP_ADD 2'h0
`define AOP_AND 2'h1
`define AOP_CP 2'h2
`define AOP_SUB 2'h3
`define MODE_DIR 2'h2
`define MODE_IMM 2'h3

// Inherent operation codes, low nibble of the misc class
`define MISC_COM 4'h0
`define MISC_RLC 4'h1
`define MISC_SLA 4'h2
`define MISC_CLRA 4'h3
`define MISC_CLRR 4'h4
`define MISC_RET 4'h9
`define MISC_INTERRUPT_RETURN 4'hA
`define MISC_STOP 4'hB
`define MISC_WAIT 4'hC

// Arithmetic unit functions
`define FN_ADD 4'h0
`define FN_AND 4'h1
`define FN_SUB 4'h2
`define FN_INC 4'h3
`define FN_DEC 4'h4
`define FN_COM 4'h5
`define FN_RLC 4'h6
`define FN_SLA 4'h7
`define FN_CLR 4'h8
`define FN_PASS 4'h9

// Cycle counts per instruction group
`define CYC_ALU 3'h4
`define CYC_REL 3'h2
`define CYC_BTB 3'h5
`define CYC_BSR 3'h4
`define CYC_CTRL 3'h2
`define CYC_JMP 3'h4

// Instruction lengths in bytes
`define LEN_1 12'h001
`define LEN_2 12'h002
`define LEN_3 12'h003

`endif

/* File: core_exec.v */
`timescale 1ns/10ps
`include "core_defines.vh"

// Fetch, decode and execute of the core instruction groups
module core_exec #(
    parameter DEPTH = 6, // Return address cells
    parameter SP_W = 3
) (
    // Clock and reset
    input wire i_clk,
    input wire i_arst_n,
    // Program memory, combinational read
    output wire [11:0] o_pm_addr,
    input wire [7:0] i_pm_data,
    // Data space, combinational read, write on clock
    output wire [7:0] o_ds_addr,
    output wire [7:0] o_ds_wdata,
    output wire o_ds_we,
    input wire [7:0] i_ds_rdata,
    // System control
    input wire i_watchdog_sel,
    input wire i_wake,
    input wire i_int_req,
    input wire [11:0] i_int_vector,
    output reg o_int_ack,
    output reg o_wait_mode,
    output reg o_stop_mode,
    // Status
    output reg [7:0] o_acc,
    output reg o_flag_z,
    output reg o_flag_c,
    output reg [11:0] o_pc,
    output reg o_instr_done
);

    localparam integer SP_TOP_I = DEPTH - 1; // Top cell, full width
    localparam [SP_W-1:0] SP_TOP = SP_TOP_I[SP_W-1:0];

    reg [2:0] cyc; // Cycle within the instruction
    reg [7:0] op; // Opcode byte
    reg [7:0] b2; // Second byte
    reg [7:0] b3; // Third byte
    reg [7:0] ptr; // Fetched pointer value
    reg [7:0] opv; // Operand value
    reg in_int; // Inside an interrupt routine
    reg save_z; // Flags held over an interrupt
    reg save_c;
    reg [SP_W-1:0] sp; // Next free stack cell
    reg [11:0] stk [0:DEPTH-1];

    // Decode, valid from the second cycle on
    wire cls_rel = ~op[7];
    wire cls_jmp = (op[7:5] == `OPC_JMP);
    wire cls_btb = (op[7:4] == `OPC_BTB);
    wire cls_bsr = (op[7:4] == `OPC_BSR);
    wire cls_alu = (op[7:4] == `OPC_ALU);
    wire cls_idc = (op[7:4] == `OPC_IDC);
    wire cls_misc = (op[7:4] == `OPC_MISC);
    wire [3:0] sub = op[3:0];
    wire is_clrr = cls_misc && (sub == `MISC_CLRR);
    wire is_ret = cls_misc && (sub == `MISC_RET);
    wire is_interrupt_return = cls_misc && (sub == `MISC_INTERRUPT_RETURN);
    wire is_stop = cls_misc && (sub == `MISC_STOP);
    wire is_wait = cls_misc && (sub == `MISC_WAIT);
    // Indirect through the first two short-direct cells
    wire ind = (cls_alu && !op[1]) ||
        (cls_idc && op[2:1] == 2'h2); // RULE_23
    wire sdir = cls_idc && !op[2]; // RULE_08
    wire imm = cls_alu && (op[1:0] == `MODE_IMM);
    wire wr_mem = cls_idc || cls_bsr || is_clrr;

    // Operand address: pointer, short-direct cell or second byte
    wire [7:0] opnd_addr = ind ? ptr :
        sdir ? (`SDIR_BASE | {6'h00, op[1:0]}) : b2; // RULE_02 RULE_23
    wire opnd_acc = (opnd_addr == `ACC_ADDR);

    reg [2:0] ncyc; // Cycle count of this instruction
    reg [11:0] nlen; // Byte length of this instruction
    reg [3:0] fn; // Arithmetic unit function
    reg upd_z; // Zero flag follows the result
    reg upd_c; // Carry flag follows the result
    reg wr_acc; // Result goes to the accumulator

    // Group decode: length, timing, function and flag effects
    always @* begin
        ncyc = `CYC_CTRL; // RULE_17
        nlen = `LEN_1; // RULE_17
        fn = `FN_PASS;
        upd_z = 1'b0;
        upd_c = 1'b0;
        wr_acc = 1'b0;
        if (cls_rel) begin
            ncyc = `CYC_REL; // RULE_11 RULE_25
        end else if (cls_jmp) begin
            ncyc = `CYC_JMP;
            nlen = `LEN_2;
        end else if (cls_btb) begin
            ncyc = `CYC_BTB; // RULE_13 RULE_25
            nlen = `LEN_3; // RULE_13
        end else if (cls_bsr) begin
            ncyc = `CYC_BSR; // RULE_15
            nlen = `LEN_2; // RULE_15
        end else if (cls_alu) begin
            // Accumulator is always the first operand
            ncyc = `CYC_ALU; // RULE_04
            nlen = ind ? `LEN_1 : `LEN_2; // RULE_04
            upd_z = 1'b1; // RULE_05
            upd_c = 1'b1; // RULE_05
            wr_acc = (op[3:2] != `AOP_CP); // RULE_01
            case (op[3:2])
                `AOP_ADD: fn = `FN_ADD; // RULE_01
                `AOP_AND: fn = `FN_AND; // RULE_01
                default: fn = `FN_SUB; // RULE_01
            endcase
        end else if (cls_idc) begin
            ncyc = `CYC_ALU; // RULE_04
            nlen = (op[2:1] == 2'h3) ? `LEN_2 : `LEN_1; // RULE_08
            fn = op[3] ? `FN_DEC : `FN_INC;
            upd_z = 1'b1; // RULE_06
        end else if (cls_misc) begin
            case (sub)
                `MISC_COM: begin
                    ncyc = `CYC_ALU; // RULE_04
                    fn = `FN_COM; // RULE_03
                end
                `MISC_RLC: begin
                    ncyc = `CYC_ALU; // RULE_04
                    fn = `FN_RLC; // RULE_03
                end
                `MISC_SLA: begin
                    ncyc = `CYC_ALU; // RULE_09
                    nlen = `LEN_2; // RULE_09
                    fn = `FN_SLA; // RULE_03
                end
                `MISC_CLRA: begin
                    ncyc = `CYC_ALU;
                    nlen = `LEN_2; // RULE_07
                    fn = `FN_CLR;
                end
                `MISC_CLRR: begin
                    // Memory clear leaves both flags alone
                    ncyc = `CYC_ALU; // RULE_07
                    nlen = `LEN_3; // RULE_07
                    fn = `FN_CLR; // RULE_07
                end
                default: ncyc = `CYC_CTRL; // RULE_17
            endcase
            if (sub <= `MISC_CLRA) begin
                upd_z = 1'b1; // RULE_05
                upd_c = 1'b1; // RULE_05
                wr_acc = 1'b1; // RULE_03
            end
        end
    end

    wire [7:0] alu_b = imm ? b2 : opv; // RULE_01
    wire [7:0] alu_res;
    wire alu_c;

    // Shared byte arithmetic
    core_alu u_alu (
        .i_a(o_acc),
        .i_b(alu_b),
        .i_cin(o_flag_c),
        .i_fn(fn),
        .o_res(alu_res),
        .o_cout(alu_c)
    );

    wire tbit = opv[op[3:1]]; // Bit under test
    wire [11:0] rel_target;
    wire [11:0] bt_target;
    wire rel_take;
    wire bt_take;

    // Branch decisions against the opcode address
    core_branch u_branch (
        .i_pc(o_pc),
        .i_op(op),
        .i_disp(b3),
        .i_flag_z(o_flag_z),
        .i_flag_c(o_flag_c),
        .i_bit(tbit),
        .o_rel_target(rel_target),
        .o_rel_take(rel_take),
        .o_bt_target(bt_target),
        .o_bt_take(bt_take)
    );

    // Bit set or clear of the fetched byte
    reg [7:0] bit_res;
    integer k;
    always @* begin
        bit_res = opv;
        for (k = 0; k < 8; k = k + 1) begin
            if (k == op[3:1]) begin
                bit_res[k] = op[0]; // RULE_15
            end
        end
    end

    wire sleeping = o_wait_mode | o_stop_mode;
    wire last = (cyc != 3'h0) && (cyc == ncyc - 3'h1);
    wire [7:0] mem_res = cls_bsr ? bit_res : alu_res;
    wire [11:0] seq_pc = o_pc + nlen;
    wire [SP_W-1:0] sp_up = (sp == SP_TOP) ? {SP_W{1'b0}} : sp + 1'b1;
    wire [SP_W-1:0] sp_dn = (sp == {SP_W{1'b0}}) ? SP_TOP : sp - 1'b1;
    // Jumps and stack users defer an interrupt, so one push per end
    wire take_int = last && i_int_req && !in_int &&
        !cls_jmp && !is_ret && !is_interrupt_return;
    wire push = take_int || (last && cls_jmp && !op[4]);
    // Flags as committed, so an interrupt saves the finished result
    wire next_z = is_interrupt_return ? save_z :
        upd_z ? (alu_res == 8'h00) : o_flag_z; // RULE_05 RULE_06 RULE_18
    wire next_c = is_interrupt_return ? save_c : cls_btb ? tbit : // RULE_21
        upd_c ? alu_c : o_flag_c; // RULE_05 RULE_18

    // Fetch walks bytes of the current instruction
    assign o_pm_addr = o_pc + {9'h000, cyc};
    // Second cycle reads a pointer cell, later ones the operand
    assign o_ds_addr = (cyc == 3'h1) ?
        (`SDIR_BASE | {7'h00, op[0]}) : opnd_addr; // RULE_23
    assign o_ds_wdata = mem_res;
    assign o_ds_we = last && wr_mem && !opnd_acc; // RULE_02

    // Next program counter at the end of an instruction
    reg [11:0] next_pc;
    always @* begin
        next_pc = seq_pc;
        if (cls_rel) begin
            next_pc = rel_take ? rel_target : seq_pc; // RULE_24
        end else if (cls_btb) begin
            next_pc = bt_take ? bt_target : seq_pc; // RULE_13 RULE_24
        end else if (cls_jmp) begin
            next_pc = {op[3:0], b2}; // RULE_20 RULE_22
        end else if (is_ret || is_interrupt_return) begin
            next_pc = stk[sp_dn];
        end
    end

    // Return stack cells, no reset needed
    always @(posedge i_clk) begin
        if (push) begin
            stk[sp] <= (cls_jmp && !op[4]) ? seq_pc : next_pc;
        end
    end

    // Sequencer, operand capture and architectural state
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cyc <= 3'h0;
            op <= 8'h00;
            b2 <= 8'h00;
            b3 <= 8'h00;
            ptr <= 8'h00;
            opv <= 8'h00;
            in_int <= 1'b0;
            save_z <= 1'b0;
            save_c <= 1'b0;
            sp <= {SP_W{1'b0}};
            o_acc <= 8'h00;
            o_flag_z <= 1'b0;
            o_flag_c <= 1'b0;
            o_pc <= 12'h000;
            o_wait_mode <= 1'b0;
            o_stop_mode <= 1'b0;
            o_int_ack <= 1'b0;
            o_instr_done <= 1'b0;
        end else begin
            o_int_ack <= take_int;
            o_instr_done <= last;
            if (sleeping) begin
                // Held at a boundary until woken
                if (i_wake || i_int_req) begin
                    o_wait_mode <= 1'b0;
                    o_stop_mode <= 1'b0;
                end
            end else if (cyc == 3'h0) begin
                op <= i_pm_data;
                cyc <= 3'h1;
            end else begin
                if (cyc == 3'h1) begin
                    b2 <= i_pm_data;
                    ptr <= i_ds_rdata;
                end
                if (cyc == 3'h2) begin
                    b3 <= i_pm_data;
                    opv <= opnd_acc ? o_acc : i_ds_rdata;
                end
                // Non-final cycles pad timing regardless of outcome
                cyc <= last ? 3'h0 : cyc + 3'h1; // RULE_25
            end
            if (last) begin
                // Return address stays in next_pc for the push
                o_pc <= take_int ? i_int_vector : next_pc;
                if (push) begin
                    sp <= sp_up;
                end else if (is_ret || is_interrupt_return) begin
                    sp <= sp_dn;
                end
                if (wr_acc || (wr_mem && opnd_acc)) begin
                    o_acc <= mem_res; // RULE_02
                end
                // Flags follow the decode, or come back on interrupt return
                o_flag_z <= next_z; // RULE_05 RULE_06 RULE_18
                o_flag_c <= next_c; // RULE_05 RULE_21 RULE_18
                if (is_interrupt_return) begin
                    in_int <= 1'b0;
                end
                // Watchdog turns a stop into a wait
                if (is_wait || (is_stop && i_watchdog_sel)) begin
                    o_wait_mode <= 1'b1; // RULE_19
                end else if (is_stop) begin
                    o_stop_mode <= 1'b1;
                end
                if (take_int) begin
                    in_int <= 1'b1;
                    save_z <= next_z;
                    save_c <= next_c;
                end
            end
        end
    end

endmodule

/* File: core_exec_chk.sv */
`timescale 1ns/10ps
// Timing and flag checks seen from the core's ports
module core_exec_chk (
    // Clock and reset
    input wire i_clk,
    input wire i_arst_n,
    // Fetch side
    input wire [11:0] o_pm_addr,
    input wire [7:0] i_pm_data,
    input wire o_ds_we,
    // System control
    input wire i_watchdog_sel,
    input wire i_int_req,
    input wire o_wait_mode,
    input wire o_stop_mode,
    // Status
    input wire o_flag_z,
    input wire o_flag_c,
    input wire [11:0] o_pc,
    input wire o_instr_done
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    // Opcode on the bus in cycle 0, awake, no interrupt pending
    wire go = o_instr_done && o_pm_addr == o_pc && !i_int_req &&
        !o_wait_mode && !o_stop_mode;
    wire [3:0] cls = i_pm_data[7:4]; // Opcode class
    rel_time_a: assert property (
        go && !i_pm_data[7] |=> !o_instr_done ##1 o_instr_done
    ) else $error("short branch cycle count wrong");
    rel_flags_a: assert property (
        go && !i_pm_data[7] |-> ##2 o_flag_z == $past(o_flag_z, 2) &&
        o_flag_c == $past(o_flag_c, 2)
    ) else $error("short branch touched a flag");
    bt_time_a: assert property (
        go && cls == 4'hA |=> !o_instr_done [*4] ##1 o_instr_done
    ) else $error("bit test branch cycle count wrong");
    bt_zero_a: assert property (
        go && cls == 4'hA |-> ##5 o_flag_z == $past(o_flag_z, 5)
    ) else $error("bit test branch touched zero flag");
    alu_time_a: assert property (
        go && cls == 4'hC |=> !o_instr_done [*3] ##1 o_instr_done
    ) else $error("arithmetic cycle count wrong");
    step_carry_a: assert property (
        go && cls == 4'hD |-> ##4 o_flag_c == $past(o_flag_c, 4)
    ) else $error("increment or decrement changed carry");
    bit_flags_a: assert property (
        go && cls == 4'hB |-> ##4 o_flag_z == $past(o_flag_z, 4) &&
        o_flag_c == $past(o_flag_c, 4)
    ) else $error("bit set or clear changed a flag");
    long_target_a: assert property (
        go && i_pm_data[7:5] == 3'b100 |-> ##4
        o_pc == {$past(i_pm_data[3:0], 4), $past(i_pm_data, 3)}
    ) else $error("jump or call target wrong");
    write_last_a: assert property (
        o_ds_we |=> !o_ds_we && o_instr_done
    ) else $error("write strobe not in last cycle");
    stop_guard_a: assert property (
        $rose(o_stop_mode) |-> !$past(i_watchdog_sel)
    ) else $error("stop entered with watchdog selected");
endmodule

bind core_exec core_exec_chk chk (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .o_pm_addr(o_pm_addr),
    .i_pm_data(i_pm_data), .o_ds_we(o_ds_we),
    .i_watchdog_sel(i_watchdog_sel), .i_int_req(i_int_req),
    .o_wait_mode(o_wait_mode), .o_stop_mode(o_stop_mode),
    .o_flag_z(o_flag_z), .o_flag_c(o_flag_c), .o_pc(o_pc),
    .o_instr_done(o_instr_done)
);

/* File: core_mem_model.sv */
`timescale 1ns/10ps
// Program memory and data space facing the core
module core_mem_model (
    // Clock
    input wire i_clk,
    // Program side, combinational read
    input wire [11:0] i_pm_addr,
    output wire [7:0] o_pm_data,
    // Data side, combinational read
    input wire [7:0] i_ds_addr,
    input wire [7:0] i_ds_wdata,
    input wire i_ds_we,
    output wire [7:0] o_ds_rdata
);
    logic [7:0] pm [0:4095]; // Program bytes, loaded by the bench
    logic [7:0] ds [0:255]; // Data bytes
    assign o_pm_data = pm[i_pm_addr];
    assign o_ds_rdata = ds[i_ds_addr];
    // Write lands on the strobe edge, like the real array
    always @(posedge i_clk) begin
        if (i_ds_we) begin
            ds[i_ds_addr] <= i_ds_wdata;
        end
    end
endmodule

/* File: tb_core_exec.sv */
`timescale 1ns/10ps
// Self-checking bench for the core instruction groups
module tb_core_exec;
    logic i_clk = 1'b0; // Core clock
    logic i_arst_n = 1'b0; // Reset, low active
    logic i_watchdog_sel = 1'b0; // Stop becomes wait when high
    logic i_wake = 1'b0; // Leaves sleep
    logic i_int_req = 1'b0; // Interrupt request
    logic [11:0] i_int_vector = 12'h200; // Handler address
    wire [11:0] pm_addr, pc;
    wire [7:0] pm_data, ds_addr, ds_wdata, ds_rdata, acc;
    wire ds_we, int_ack, wait_mode, stop_mode, flag_z, flag_c, done;
    int bad_count = 0;
    int checks_done = 0;
    logic [19:0] img[$]; // {address, byte}
    logic [15:0] dsq[$]; // {address, byte} data preload
    logic [23:0] expq[$]; // {acc, pc, 2'b0, z, c} per instruction
    always #5 i_clk = ~i_clk;
    core_mem_model mem (.i_clk(i_clk), .i_pm_addr(pm_addr),
        .o_pm_data(pm_data), .i_ds_addr(ds_addr), .i_ds_wdata(ds_wdata),
        .i_ds_we(ds_we), .o_ds_rdata(ds_rdata));
    core_exec uut (.i_clk(i_clk), .i_arst_n(i_arst_n),
        .o_pm_addr(pm_addr), .i_pm_data(pm_data), .o_ds_addr(ds_addr),
        .o_ds_wdata(ds_wdata), .o_ds_we(ds_we), .i_ds_rdata(ds_rdata),
        .i_watchdog_sel(i_watchdog_sel), .i_wake(i_wake),
        .i_int_req(i_int_req), .i_int_vector(i_int_vector),
        .o_int_ack(int_ack), .o_wait_mode(wait_mode),
        .o_stop_mode(stop_mode), .o_acc(acc), .o_flag_z(flag_z),
        .o_flag_c(flag_c), .o_pc(pc), .o_instr_done(done));
    // Compare and count
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    // Bounded wait for the end-of-instruction pulse
    task automatic wait_done();
        int n = 0;
        do begin
            @(posedge i_clk);
            #1;
            n++;
        end while (done !== 1'b1 && n < 20);
        if (done !== 1'b1) chk(1'b0, 1'b1);
    endtask
    // Hold reset while memories load, then step through the table
    task automatic run_img();
        @(posedge i_clk);
        i_arst_n <= 1'b0;
        for (int i = 0; i < 4096; i++) mem.pm[i] = 8'hE5;
        for (int i = 0; i < 256; i++) mem.ds[i] = 8'h00;
        foreach (img[i]) mem.pm[img[i][19:8]] = img[i][7:0];
        foreach (dsq[i]) mem.ds[dsq[i][15:8]] = dsq[i][7:0];
        repeat (6) @(posedge i_clk);
        i_arst_n <= 1'b1;
        foreach (expq[i]) begin
            wait_done();
            chk({acc, pc, 2'b00, flag_z, flag_c}, expq[i]);
        end
    endtask
    // Accumulator operations, immediate, direct and indirect through 80h
    task automatic t_alu();
        img = '{20'h0_00E3, 20'h0_0100, 20'h0_02C3, 20'h0_0390, 20'h0_04C0,
            20'h0_05C2, 20'h0_0685, 20'h0_07CF, 20'h0_0890, 20'h0_09CB,
            20'h0_0A01, 20'h0_0BE0, 20'h0_0CE1, 20'h0_0DE2, 20'h0_0E00,
            20'h0_0FC7, 20'h0_1003};
        dsq = '{16'h8085, 16'h8580};
        expq = '{24'h00_0022, 24'h90_0040, 24'h10_0051, 24'h90_0070,
            24'h00_0092, 24'h00_00B1, 24'hFF_00C0, 24'hFE_00D1,
            24'hFC_00F1, 24'h00_0112};
        run_img();
        $display("alu test done");
    endtask
    // Step, clear, bit set and bit test; 41h is plain RAM, not a port
    task automatic t_mem();
        img = '{20'h0_00CB, 20'h0_0101, 20'h0_02D2, 20'h0_03DE, 20'h0_0440,
            20'h0_05E4, 20'h0_0640, 20'h0_08B7, 20'h0_0941,
            20'h0_0AA7, 20'h0_0B41, 20'h0_0C04, 20'h0_10A6, 20'h0_1141,
            20'h0_1205, 20'h0_13A8, 20'h0_1441, 20'h0_157F, 20'h0_94DE,
            20'h0_95FF};
        dsq = '{16'h82FF, 16'h4005};
        expq = '{24'h00_0021, 24'h00_0033, 24'h00_0051,
            24'h00_0081, 24'h00_00A1, 24'h00_0101,
            24'h00_0131, 24'h00_0940, 24'hFF_0960};
        run_img();
        chk(mem.ds[8'h82], 8'h00);
        chk(mem.ds[8'h40], 8'h00);
        chk(mem.ds[8'h41], 8'h08);
        $display("data space test done");
    endtask
    // Short branches both ways, range ends, jump, call, return
    task automatic t_branch();
        img = '{20'h0_000F, 20'h0_1030, 20'h0_0140, 20'h0_0260, 20'h0_03CB,
            20'h0_0401, 20'h0_0563, 20'h0_0922, 20'h0_0ACB, 20'h0_0B00,
            20'h0_0C45, 20'h0_1205, 20'h0_139A, 20'h0_1434, 20'hA_3481,
            20'hA_3520, 20'h1_20E9};
        dsq = {};
        expq = '{24'h00_0100, 24'h00_0010, 24'h00_0020,
            24'h00_0030, 24'h00_0051, 24'h00_0091, 24'h00_00A1,
            24'h00_00C2, 24'h00_0122, 24'h00_0132, 24'h00_A342,
            24'h00_1202, 24'h00_A362, 24'h00_A372};
        run_img();
        $display("branch test done");
    endtask
    // One-cycle wake request
    task automatic wake();
        @(posedge i_clk);
        i_wake <= 1'b1;
        i_watchdog_sel <= 1'b0;
        @(posedge i_clk);
        i_wake <= 1'b0;
        repeat (6) @(posedge i_clk);
        #1;
    endtask
    // Stop under watchdog, stop, wait, then an interrupt round trip
    task automatic t_sleep();
        img = '{20'h0_00EB, 20'h0_01EB, 20'h0_02EC, 20'h0_03CB, 20'h0_0400,
            20'h2_00CB, 20'h2_0101, 20'h2_02EA};
        dsq = {};
        expq = {};
        @(posedge i_clk);
        i_watchdog_sel <= 1'b1;
        run_img();
        repeat (6) @(posedge i_clk);
        #1;
        chk({wait_mode, stop_mode, pc}, {2'b10, 12'h001});
        wake();
        chk({wait_mode, stop_mode, pc}, {2'b01, 12'h002});
        wake();
        chk({wait_mode, stop_mode, pc}, {2'b10, 12'h003});
        wake();
        @(posedge i_clk);
        i_int_req <= 1'b1;
        repeat (40) begin
            @(posedge i_clk);
            #1;
            if (int_ack === 1'b1) break;
        end
        chk(int_ack, 1'b1);
        @(posedge i_clk);
        i_int_req <= 1'b0;
        repeat (40) begin
            @(posedge i_clk);
            #1;
            if (done === 1'b1 && pc < 12'h200) break;
        end
        chk({pc < 12'h200, flag_z, flag_c}, 3'b110);
        $display("control test done");
    endtask
    // Verdict and end of run
    task automatic summarize();
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Hang guard, well past the few hundred cycles needed
    initial begin
        #200000;
        bad_count++;
        summarize();
    end
    // Main sequence
    initial begin
        t_alu();
        t_mem();
        t_branch();
        t_sleep();
        summarize();
    end
endmodule
